// ===== design/cgss_pkg.sv
/*
  cgss_pkg: constants, tables and types shared by the strap latch and
  serial slave. Assumes the including files import the whole package.
*/
package cgss_pkg;

  // serial slave
  localparam logic [6:0] CGSS_SLAVE_ADDR7 = 7'h69;
  localparam int         CGSS_NUM_REGS    = 8;
  localparam logic [6:0] CGSS_REG_FREQ    = 7'h04;
  localparam logic [6:0] CGSS_REG_MODE    = 7'h06;
  localparam logic [6:0] CGSS_REG_STATUS  = 7'h07;
  localparam logic [7:0] CGSS_REG_RESET [CGSS_NUM_REGS] =
    '{8'hff, 8'hff, 8'hff, 8'hf6, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam int         CGSS_MODE_I2C_BIT  = 0;
  localparam int         CGSS_MODE_SOFT_BIT = 1;
  localparam int         CGSS_CMD_SINGLE_BIT = 7;
  localparam logic [6:0] CGSS_BLOCK_OFFSET = 7'h00;
  localparam logic [7:0] CGSS_BLOCK_COUNT  = 8'h08;
  localparam logic [3:0] CGSS_BITS_BYTE    = 4'h8;
  localparam logic [3:0] CGSS_ACK_SLOT     = 4'h9;

  // host frequency tables in kHz and cpu pll tables, indexed by the low three code bits
  localparam logic [19:0] CGSS_HOST_A_KHZ [8] = '{20'h411ab, 20'h208d5, 20'h30d40,
    20'h28b0b, 20'h51615, 20'h186a0, 20'h61a80, 20'h30d40};
  localparam logic [19:0] CGSS_HOST_B_KHZ [8] = '{20'h411ab, 20'h208d5, 20'h30d40,
    20'h28b0b, 20'h51615, 20'h186a0, 20'h61a80, 20'h3d090};
  localparam logic [7:0]  CGSS_CPU_GEAR [8] = '{8'h50, 8'h28, 8'h3c, 8'h3c,
    8'h78, 8'h1e, 8'h78, 8'h3c};
  localparam logic [7:0]  CGSS_CPU_M [8] = '{8'h3c, 8'h3c, 8'h3c, 8'h3f,
    8'h3f, 8'h3c, 8'h3c, 8'h3c};
  localparam logic [7:0]  CGSS_CPU_N [8] = '{8'hc8, 8'hc8, 8'hc8, 8'haf,
    8'haf, 8'hc8, 8'hc8, 8'hfa};
  localparam logic [19:0] CGSS_SRC_KHZ     = 20'h186a0;
  localparam logic [19:0] CGSS_PCI_KHZ     = 20'h08235;
  localparam logic [19:0] CGSS_LINK_LO_KHZ = 20'h1046b;
  localparam logic [19:0] CGSS_LINK_HI_KHZ = 20'h208d5;
  localparam logic [7:0]  CGSS_PCIE_GEAR   = 8'h1e;
  localparam logic [7:0]  CGSS_PCIE_M      = 8'h3c;
  localparam logic [7:0]  CGSS_PCIE_N      = 8'hc8;

  typedef enum logic [2:0] {
    CGSS_IDLE  = 3'b000,
    CGSS_ADDR  = 3'b001,
    CGSS_CMD   = 3'b010,
    CGSS_COUNT = 3'b011,
    CGSS_WDATA = 3'b100,
    CGSS_TX    = 3'b101
  } cgss_state_t;

endpackage

// ===== design/cgss_reg_if.sv
/*
  cgss_reg_if: carries writes, reads and register contents between the
  slave and its register file. Assumes one clock for both ends.
*/
`timescale 1ns/1ps
interface cgss_reg_if;
  import cgss_pkg::*;
  logic       wr_en;
  logic [6:0] addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] status;
  logic [7:0] cfg [CGSS_NUM_REGS];
  modport ctrl (output wr_en, addr, wr_data, status, input rd_data, cfg);
  modport mem  (input wr_en, addr, wr_data, status, output rd_data, cfg);
endinterface

// ===== design/cgss_sync.sv
/*
  cgss_sync: two-stage synchroniser for a group of asynchronous inputs.
  Assumes the inputs come from pins outside the clk domain.
*/
`timescale 1ns/1ps
module cgss_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // cgss_sync

// ===== design/cgss_regfile.sv
/*
  cgss_regfile: configuration bytes with registered read data and a
  read-only status byte. Assumes writes arrive as single-cycle strobes.
*/
`timescale 1ns/1ps
module cgss_regfile (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // register access
  cgss_reg_if.mem   bus
);
  import cgss_pkg::*;

  wire wr_hit = bus.wr_en && (bus.addr < CGSS_REG_STATUS);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < CGSS_NUM_REGS; i++) begin
        bus.cfg[i] <= CGSS_REG_RESET[i]; // [R07] [R21]
      end
    end else if (wr_hit) begin
      bus.cfg[bus.addr[2:0]] <= bus.wr_data; // [R23]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      bus.rd_data <= 8'h00;
    end else if (bus.addr == CGSS_REG_STATUS) begin
      bus.rd_data <= bus.status;
    end else if (bus.addr < CGSS_REG_STATUS) begin
      bus.rd_data <= bus.cfg[bus.addr[2:0]];
    end else begin
      bus.rd_data <= 8'h00;
    end
  end
endmodule // cgss_regfile

// ===== design/cgss_top.sv
/*
  cgss_top: frequency strap latch, frequency decode and two-wire
  configuration slave. Assumes scl, sda and all straps are asynchronous
  pins, and that sda is open drain with an external pull-up.
*/
`timescale 1ns/1ps
// Behaviour
// [R01] straps valid before power-good goes low
// [R02] latch straps when power-good sampled low
// [R03] one-shot latch, test mode re-latches
// [R04] code selects both host clock frequencies
// [R05] fixed reference, pci; link follows top bit
// [R06] serial bytes enable each clock output
// [R07] registers load defaults at power-up
// [R08] controller configures only at initialisation
// [R09] byte and block, read and write
// [R10] block bytes ascend, msb first, stoppable
// [R11] answer slave address d2h
// [R12] command bit 7 selects byte or block
// [R13] command bits 6..0 give byte offset
// [R14] block write carries count unless compatible
// [R15] block read returns count then data
// [R16] controller nacks final read byte, stops
// [R17] byte write: address, command, data, stop
// [R18] byte read uses repeated start, one byte
// [R19] latched power-good becomes power-down request
// [R20] soft bits supply the frequency code
// [R21] reset restores every register default
// [R22] ignore transactions for other addresses
// [R23] writes to unimplemented offsets change nothing
module cgss_top
  import cgss_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // straps and power-good
  input  wire logic        test_mode,
  input  wire logic        freq_strap_bit0,
  input  wire logic        freq_strap_bit1,
  input  wire logic        freq_strap_bit2,
  input  wire logic        freq_strap_bit3,
  input  wire logic        proc_power_good_n,
  // two-wire serial pins
  input  wire logic        scl,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // strap state
  output logic [3:0]       freq_code,
  output logic             code_latched,
  output logic             power_down_request,
  // clock configuration
  output logic [31:0]      clock_out_enable,
  output logic [19:0]      host_clock_a_khz,
  output logic [19:0]      host_clock_b_khz,
  output logic [19:0]      serial_reference_clock_khz,
  output logic [19:0]      link_clock_khz,
  output logic [19:0]      pci_clock_khz,
  output logic [7:0]       cpu_pll_gear,
  output logic [7:0]       cpu_pll_m,
  output logic [7:0]       cpu_pll_n,
  output logic [7:0]       pcie_pll_gear,
  output logic [7:0]       pcie_pll_m,
  output logic [7:0]       pcie_pll_n
);
  import cgss_pkg::*;

  cgss_reg_if  rbus ();

  logic [7:0]  sync_q;
  logic        scl_s;
  logic        sda_s;
  logic        pg_n_s;
  logic [3:0]  strap_s;
  logic        scl_prev;
  logic        sda_prev;
  logic [3:0]  strap_code;
  cgss_state_t state;
  cgss_state_t next_state;
  logic [3:0]  bitcnt;
  logic [7:0]  rx;
  logic [7:0]  tx;
  logic [6:0]  ptr;
  logic        tx_count;
  logic        master_nack;
  logic        block_mode;
  logic        test_s;

  cgss_sync #(.W(8), .INIT(8'h7f)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({test_mode, scl, sda_i, proc_power_good_n, freq_strap_bit3, freq_strap_bit2,
            freq_strap_bit1, freq_strap_bit0}),
    .q    (sync_q)
  );

  cgss_regfile u_regs (
    .clk  (clk),
    .rstn (rstn),
    .bus  (rbus)
  );

  assign test_s  = sync_q[7];
  assign scl_s   = sync_q[6];
  assign sda_s   = sync_q[5];
  assign pg_n_s  = sync_q[4];
  assign strap_s = sync_q[3:0];

  // strap latch
  wire take_strap = !pg_n_s && (!code_latched || test_s); // [R02] [R03]

  always_ff @(posedge clk) begin
    if (!rstn) begin
      code_latched <= 1'b0;
      strap_code   <= 4'h0;
    end else if (take_strap) begin
      code_latched <= 1'b1;
      strap_code   <= strap_s; // [R02]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      power_down_request <= 1'b0;
    end else begin
      power_down_request <= code_latched && pg_n_s; // [R19]
    end
  end

  // frequency decode
  wire [3:0] soft_freq_code = rbus.cfg[CGSS_REG_FREQ[2:0]][3:0];
  wire       soft_sel       = rbus.cfg[CGSS_REG_MODE[2:0]][CGSS_MODE_SOFT_BIT];
  wire       i2c_compat     = rbus.cfg[CGSS_REG_MODE[2:0]][CGSS_MODE_I2C_BIT];
  wire [3:0] eff_code       = soft_sel ? soft_freq_code : strap_code; // [R20]
  wire [2:0] row            = eff_code[2:0];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      freq_code        <= 4'h0;
      host_clock_a_khz <= CGSS_HOST_A_KHZ[0];
      host_clock_b_khz <= CGSS_HOST_B_KHZ[0];
      link_clock_khz   <= CGSS_LINK_LO_KHZ;
      cpu_pll_gear     <= CGSS_CPU_GEAR[0];
      cpu_pll_m        <= CGSS_CPU_M[0];
      cpu_pll_n        <= CGSS_CPU_N[0];
    end else begin
      freq_code        <= eff_code;
      host_clock_a_khz <= CGSS_HOST_A_KHZ[row]; // [R04]
      host_clock_b_khz <= CGSS_HOST_B_KHZ[row]; // [R04]
      link_clock_khz   <= eff_code[3] ? CGSS_LINK_HI_KHZ : CGSS_LINK_LO_KHZ; // [R05]
      cpu_pll_gear     <= CGSS_CPU_GEAR[row];
      cpu_pll_m        <= CGSS_CPU_M[row];
      cpu_pll_n        <= CGSS_CPU_N[row];
    end
  end

  // fixed for every code; enables and status follow the registers and the latch
  assign serial_reference_clock_khz = CGSS_SRC_KHZ; // [R05]
  assign pci_clock_khz              = CGSS_PCI_KHZ; // [R05]
  assign pcie_pll_gear              = CGSS_PCIE_GEAR;
  assign pcie_pll_m                 = CGSS_PCIE_M;
  assign pcie_pll_n                 = CGSS_PCIE_N;
  assign clock_out_enable = {rbus.cfg[3], rbus.cfg[2], rbus.cfg[1], rbus.cfg[0]}; // [R06]
  assign rbus.status = {code_latched, power_down_request, 2'b00, freq_code};

  // bus conditions
  always_ff @(posedge clk) begin
    if (!rstn) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  wire rise       = scl_s && !scl_prev;
  wire fall       = !scl_s && scl_prev;
  wire start_cond = scl_s && scl_prev && sda_prev && !sda_s;
  wire stop_cond  = scl_s && scl_prev && !sda_prev && sda_s;
  wire active     = (state != CGSS_IDLE);
  wire rx_mode    = active && (state != CGSS_TX);
  wire addr_hit   = (rx[7:1] == CGSS_SLAVE_ADDR7); // [R11]
  wire byte_done  = active && fall && (bitcnt == CGSS_BITS_BYTE);
  wire slot_end   = active && fall && (bitcnt == CGSS_ACK_SLOT);
  wire ack_now    = byte_done && rx_mode && ((state != CGSS_ADDR) || addr_hit); // [R22]
  wire tx_load_now = slot_end && (state == CGSS_TX) && !master_nack; // [R16]
  wire [7:0] tx_load = tx_count ? CGSS_BLOCK_COUNT : rbus.rd_data; // [R15]
  wire tx_shift   = fall && (state == CGSS_TX) && (bitcnt != 4'h0) &&
                    (bitcnt < CGSS_BITS_BYTE);
  wire cmd_single = rx[CGSS_CMD_SINGLE_BIT];

  // transaction sequencing
  always_comb begin
    next_state = state;
    if (start_cond) begin
      next_state = CGSS_ADDR;
    end else if (stop_cond) begin
      next_state = CGSS_IDLE;
    end else if (byte_done) begin
      case (state)
        CGSS_ADDR: begin
          if (!addr_hit) begin
            next_state = CGSS_IDLE; // [R22]
          end else if (rx[0]) begin
            next_state = CGSS_TX; // [R15] [R18]
          end else begin
            next_state = CGSS_CMD;
          end
        end
        CGSS_CMD: begin
          if (!cmd_single && !i2c_compat) begin
            next_state = CGSS_COUNT; // [R12] [R14]
          end else begin
            next_state = CGSS_WDATA; // [R17]
          end
        end
        CGSS_COUNT: next_state = CGSS_WDATA; // [R14]
        default:    next_state = state;
      endcase
    end else if (slot_end && (state == CGSS_TX) && master_nack) begin
      next_state = CGSS_IDLE; // [R16]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= CGSS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // bit counter counts rising edges, then one acknowledge slot
  always_ff @(posedge clk) begin
    if (!rstn || start_cond || stop_cond) begin
      bitcnt <= 4'h0;
    end else if (slot_end) begin
      bitcnt <= 4'h0;
    end else if (rise && active && (bitcnt < CGSS_ACK_SLOT)) begin
      bitcnt <= bitcnt + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx <= 8'h00;
    end else if (rise && (bitcnt < CGSS_BITS_BYTE)) begin
      rx <= {rx[6:0], sda_s}; // [R10]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      master_nack <= 1'b0;
    end else if (byte_done && (state == CGSS_ADDR)) begin
      master_nack <= 1'b0;
    end else if (rise && (state == CGSS_TX) && (bitcnt == CGSS_BITS_BYTE)) begin
      master_nack <= sda_s; // [R16]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx <= 8'h00;
    end else if (tx_load_now) begin
      tx <= tx_load;
    end else if (tx_shift) begin
      tx <= {tx[6:0], 1'b0}; // [R10]
    end
  end

  // pointer: offset from command, ascending in blocks
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ptr      <= 7'h00;
      tx_count <= 1'b0;
    end else if (byte_done && (state == CGSS_CMD)) begin
      ptr      <= cmd_single ? rx[6:0] : CGSS_BLOCK_OFFSET; // [R13]
      tx_count <= 1'b0;
    end else if (byte_done && (state == CGSS_ADDR) && addr_hit && rx[0]) begin
      tx_count <= !rbus.cfg[CGSS_REG_MODE[2:0]][CGSS_MODE_I2C_BIT] && block_mode;
    end else if (byte_done && (state == CGSS_WDATA)) begin
      ptr <= ptr + 7'h01; // [R10]
    end else if (byte_done && (state == CGSS_TX)) begin
      if (tx_count) begin
        tx_count <= 1'b0; // [R15]
      end else begin
        ptr <= ptr + 7'h01; // [R10]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      block_mode <= 1'b0;
    end else if (byte_done && (state == CGSS_CMD)) begin
      block_mode <= !cmd_single; // [R12]
    end
  end

  // open-drain data line
  always_ff @(posedge clk) begin
    if (!rstn || start_cond || stop_cond) begin
      sda_oe <= 1'b0;
    end else if (ack_now) begin
      sda_oe <= 1'b1; // [R09] [R23]
    end else if (tx_load_now) begin
      sda_oe <= !tx_load[7];
    end else if (tx_shift) begin
      sda_oe <= !tx[6];
    end else if (byte_done || slot_end) begin
      sda_oe <= 1'b0;
    end
  end

  assign sda_o        = 1'b0;
  assign rbus.addr    = ptr;
  assign rbus.wr_data = rx;
  assign rbus.wr_en   = byte_done && (state == CGSS_WDATA); // [R09] [R17]

endmodule // cgss_top

// ===== test/cgss_assertions.sv
/* cgss_assertions: port checks on cgss_top.
   Assumes one clock and synchronous active-low reset. */
`timescale 1ns/1ps
module cgss_assertions
  import cgss_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // watched ports
  input wire logic        proc_power_good_n,
  input wire logic        scl,
  input wire logic        sda_oe,
  input wire logic [3:0]  freq_code,
  input wire logic        code_latched,
  input wire logic        power_down_request,
  input wire logic [19:0] host_clock_a_khz,
  input wire logic [19:0] link_clock_khz
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_pd_needs_latch: assert property (power_down_request |-> code_latched)
    else $error("power-down before latch");
  chk_latch_sticky: assert property (code_latched |=> code_latched)
    else $error("latch lost");
  chk_latch_time: assert property (
    $fell(proc_power_good_n) && !code_latched |-> ##[1:4] code_latched)
    else $error("late latch");
  chk_pd_on: assert property (
    (code_latched && proc_power_good_n)[*5] |-> power_down_request)
    else $error("no power-down");
  chk_pd_off: assert property (!proc_power_good_n[*5] |-> !power_down_request)
    else $error("stray power-down");
  chk_link_rule: assert property ($stable(freq_code)[*3] |->
    link_clock_khz == (freq_code[3] ? CGSS_LINK_HI_KHZ : CGSS_LINK_LO_KHZ))
    else $error("link frequency");
  chk_host_table: assert property ($stable(freq_code)[*3] |->
    host_clock_a_khz == CGSS_HOST_A_KHZ[freq_code[2:0]])
    else $error("host frequency");
  chk_sda_scl_low: assert property ($changed(sda_oe) |-> !scl)
    else $error("sda moved while scl high");
  chk_idle_release: assert property (scl[*8] |-> !sda_oe)
    else $error("sda held while idle");
endmodule // cgss_assertions

bind cgss_top cgss_assertions chk (
  .clk(clk), .rstn(rstn), .proc_power_good_n(proc_power_good_n), .scl(scl),
  .sda_oe(sda_oe), .freq_code(freq_code), .code_latched(code_latched),
  .power_down_request(power_down_request), .host_clock_a_khz(host_clock_a_khz),
  .link_clock_khz(link_clock_khz));

// ===== test/cgss_host_model.sv
/* cgss_host_model: two-wire controller and power sequencer.
   Assumes sda has a pull-up, so releasing means driving 1. */
`timescale 1ns/1ps
module cgss_host_model (
  // clock
  input  wire logic  clk,
  // pins
  input  wire logic  sda,
  output logic       scl,
  output logic       sda_h,
  output logic [3:0] strap,
  output logic       pg_n
);
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
    strap = 4'h0;
    pg_n = 1'b1;
  end
  task automatic hb();
    repeat (4) @(negedge clk);
  endtask
  task automatic pins(input logic [3:0] s, input logic p);
    strap = s;
    pg_n = p;
  endtask
  task automatic power_up(input logic [3:0] c);
    strap = c;
    hb();
    pg_n = 1'b0;
  endtask
  task automatic start();
    sda_h = 1'b1;
    hb();
    scl = 1'b1;
    hb();
    sda_h = 1'b0;
    hb();
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_h = 1'b0;
    hb();
    scl = 1'b1;
    hb();
    sda_h = 1'b1;
    hb();
  endtask
  task automatic bitx(input logic b, output logic r);
    sda_h = b;
    repeat (2) @(negedge clk); // 80 ns bit: scl low 4 clk, high 4 clk
    scl = 1'b1;
    hb();
    r = sda;
    scl = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
    end
    bitx(1'b1, r);
    a = !r;
  endtask
  task automatic rd(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(nack, r);
  endtask
endmodule // cgss_host_model

// ===== test/cgss_tb_top.sv
/* cgss_tb_top: self-checking bench for cgss_top.
   Assumes the host model drives scl, sda and the straps. */
`timescale 1ns/1ps
module cgss_tb_top;
  import cgss_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        test_mode = 1'b0;
  logic        scl, sda_h, pg_n, sda_oe, code_latched, pdr, sdo;
  logic [7:0]  cg, cm, cn, eg, em, en;
  logic [3:0]  strap, freq_code;
  logic [31:0] coe, s;
  logic [19:0] ha, hbk, src, link, pci;
  logic [7:0]  bf [8];
  wire logic   sda = sda_h & ~sda_oe;
  int          n_errors = 0, compares = 0, seed = 96, na;
  always #5 clk = ~clk;
  cgss_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_h(sda_h),
    .strap(strap), .pg_n(pg_n));
  cgss_top uut (.clk(clk), .rstn(rstn), .test_mode(test_mode),
    .freq_strap_bit0(strap[0]), .freq_strap_bit1(strap[1]),
    .freq_strap_bit2(strap[2]), .freq_strap_bit3(strap[3]),
    .proc_power_good_n(pg_n), .scl(scl), .sda_i(sda), .sda_o(sdo), .sda_oe(sda_oe),
    .freq_code(freq_code), .code_latched(code_latched), .power_down_request(pdr),
    .clock_out_enable(coe), .host_clock_a_khz(ha), .host_clock_b_khz(hbk),
    .serial_reference_clock_khz(src), .link_clock_khz(link), .pci_clock_khz(pci),
    .cpu_pll_gear(cg), .cpu_pll_m(cm), .cpu_pll_n(cn), .pcie_pll_gear(eg),
    .pcie_pll_m(em), .pcie_pll_n(en));
  task automatic stop_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  function automatic logic [19:0] exp_link(input logic [3:0] k);
    return k[3] ? 20'h208d5 : 20'h1046b;
  endfunction
  task automatic dec(input logic [3:0] k);
    logic [2:0] r;
    r = k[2:0];
    chk(freq_code === k, "code");
    chk(cg === CGSS_CPU_GEAR[r] && cm === CGSS_CPU_M[r], "cpu pll");
    chk(cn === CGSS_CPU_N[r], "cpu pll n");
    chk(eg === 8'h1e && em === 8'h3c && en === 8'hc8, "pcie pll");
    chk(ha === CGSS_HOST_A_KHZ[k[2:0]] && hbk === CGSS_HOST_B_KHZ[k[2:0]], "host");
    chk(link === exp_link(k) && src === 20'h186a0 && pci === 20'h08235, "fixed");
  endtask
  task automatic wtx(input logic [7:0] adr, input logic [7:0] cmd, input int n);
    logic a;
    na = 0;
    host.start();
    host.wr(adr, a);
    na += a;
    host.wr(cmd, a);
    na += a;
    for (int i = 0; i < n; i++) begin
      host.wr(bf[i], a);
      na += a;
    end
    host.stop();
  endtask
  task automatic rtx(input logic [7:0] cmd, input int n);
    logic a;
    na = 0;
    host.start();
    host.wr(8'hd2, a);
    na += a;
    host.wr(cmd, a);
    na += a;
    host.start();
    host.wr(8'hd3, a);
    na += a;
    for (int i = 0; i < n; i++) begin
      host.rd(i == n - 1, bf[i]);
    end
    host.stop();
  endtask
  initial begin
    #500000;
    n_errors++;
    $display("unexpected at %0t: watchdog timeout", $time);
    stop_test();
  end
  initial begin
    logic [3:0] c;
    logic [7:0] v;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    chk(coe === 32'hf6ffffff && code_latched === 1'b0 && sdo === 1'b0, "reset");
    repeat (4) @(negedge clk);
    c = 4'($random(seed));
    host.power_up(c);
    repeat (8) @(negedge clk);
    chk(code_latched === 1'b1, "latch");
    dec(c);
    host.pins(~c, 1'b1);
    repeat (8) @(negedge clk);
    chk(pdr === 1'b1 && freq_code === c, "power-down");
    host.pins(~c, 1'b0);
    repeat (8) @(negedge clk);
    chk(pdr === 1'b0 && freq_code === c, "one-shot");
    test_mode = 1'b1;
    for (int k = 0; k < 16; k++) begin
      host.pins(4'(k), 1'b0);
      repeat (8) @(negedge clk);
      dec(4'(k));
    end
    test_mode = 1'b0;
    host.pins(4'h2, 1'b0);
    repeat (8) @(negedge clk);
    chk(freq_code === 4'hf, "test mode off");
    v = 8'($random(seed));
    bf[0] = v;
    wtx(8'hd2, 8'h81, 1);
    chk(na === 3 && coe[15:8] === v, "byte write");
    rtx(8'h81, 1);
    chk(na === 3 && bf[0] === v, "byte read");
    bf[0] = ~v;
    wtx(8'hd4, 8'h81, 1);
    chk(na === 0 && coe[15:8] === v, "foreign address");
    s = coe;
    wtx(8'hd2, 8'h87, 1);
    wtx(8'hd2, 8'hff, 1);
    chk(na === 3 && coe === s, "unused offset");
    bf[0] = 8'h04;
    for (int i = 1; i < 5; i++) begin
      bf[i] = 8'($random(seed));
    end
    wtx(8'hd2, 8'h00, 5);
    s = {bf[4], bf[3], bf[2], bf[1]};
    chk(na === 7 && coe === s, "block write");
    rtx(8'h00, 4);
    chk(na === 3 && bf[0] === CGSS_BLOCK_COUNT, "block count");
    chk({bf[3], bf[2], bf[1]} === s[23:0], "block read");
    c = 4'($random(seed));
    bf[0] = {4'h0, c};
    wtx(8'hd2, 8'h84, 1);
    bf[0] = 8'h03;
    wtx(8'hd2, 8'h86, 1);
    chk(freq_code === c, "soft code");
    bf[0] = 8'h5a;
    bf[1] = 8'ha5;
    wtx(8'hd2, 8'h00, 2);
    chk(na === 4 && coe[15:0] === 16'ha55a, "no-count block");
    rstn = 1'b0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    chk(coe === 32'hf6ffffff && freq_code === 4'h0, "mid-run reset");
    stop_test();
  end
endmodule // cgss_tb_top
